// ==== rtl/spsc_pkg.sv ====
// Purpose: constants for the port status and host port control registers
// Assumes: 16-bit register window, byte offsets as printed
// Notes: one bank holds both registers; the bank is chosen outside this block
package spsc_pkg;
   localparam int unsigned SPSC_AW = 8;
   localparam int unsigned SPSC_DW = 16;
   // register offsets
   localparam logic [7:0] SPSC_OFF_HOST_CTL2 = 8'h02;
   localparam logic [7:0] SPSC_OFF_LINK_STAT = 8'h04;
   // link status field positions
   localparam int unsigned SPSC_ST_XOVER = 15;
   localparam int unsigned SPSC_ST_POLREV = 13;
   localparam int unsigned SPSC_ST_RXFC = 12;
   localparam int unsigned SPSC_ST_TXFC = 11;
   localparam int unsigned SPSC_ST_SPEED = 10;
   localparam int unsigned SPSC_ST_DUPLEX = 9;
   localparam int unsigned SPSC_ST_MDI = 7;
   localparam int unsigned SPSC_ST_ANDONE = 6;
   localparam int unsigned SPSC_ST_LINK = 5;
   localparam int unsigned SPSC_ST_LP_PAUSE = 4;
   localparam int unsigned SPSC_ST_LP_100FD = 3;
   localparam int unsigned SPSC_ST_LP_100HD = 2;
   localparam int unsigned SPSC_ST_LP_10FD = 1;
   localparam int unsigned SPSC_ST_LP_10HD = 0;
   // host port control field positions
   localparam int unsigned SPSC_CT_VLAN_FILT = 14;
   localparam int unsigned SPSC_CT_NONPVID = 13;
   localparam int unsigned SPSC_CT_TX_EN = 10;
   localparam int unsigned SPSC_CT_RX_EN = 9;
   localparam int unsigned SPSC_CT_LEARN_DIS = 8;
   localparam int unsigned SPSC_CT_MIRROR_DST = 7;
   localparam int unsigned SPSC_CT_RX_SNIFF = 6;
   localparam int unsigned SPSC_CT_TX_SNIFF = 5;
   // writable masks and reset values
   localparam logic [15:0] SPSC_ST_WMASK = 16'h8000;
   localparam logic [15:0] SPSC_ST_RESET = 16'h8000;
   localparam logic [15:0] SPSC_CT_WMASK = 16'h67e0;
   localparam logic [15:0] SPSC_CT_RESET = 16'h0600;
   localparam logic [2:0] SPSC_MEMB_HOST = 3'h4;
endpackage

// ==== rtl/spsc_regbit.sv ====
// Purpose: bank of writable register bits with write mask and reset value
// Assumes: synchronous active-low reset
// Notes: bits outside the mask hold zero
`timescale 1ns/10ps
`default_nettype none
module spsc_regbit #(
   parameter int unsigned W = 16,
   parameter logic [15:0] MASK = 16'h0000,
   parameter logic [15:0] RST = 16'h0000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // write port
   input wire logic we_i,
   input wire logic [W-1:0] wdata_i,
   // stored value
   output logic [W-1:0] q_o
);
   // mask and reset value are 16 bits wide
   if (W != 16) begin : g_bad_width
      $error("spsc_regbit: width must be 16");
   end
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         if (MASK[g]) begin : g_rw
            logic bit_reg;
            always_ff @(posedge clk_i) begin
               if (!rstn_i) begin
                  bit_reg <= RST[g];
               end else if (we_i) begin
                  bit_reg <= wdata_i[g];
               end
            end
            assign q_o[g] = bit_reg;
         end else begin : g_ro
            assign q_o[g] = 1'b0;
         end
      end
   endgenerate
endmodule // spsc_regbit
`default_nettype wire

// ==== rtl/spsc_gate.sv ====
// Purpose: per-packet decisions made from host port control bits
// Assumes: packet qualifiers are single-cycle strobes
// Notes: outputs registered
`timescale 1ns/10ps
`default_nettype none
module spsc_gate
   import spsc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // control
   input wire logic [15:0] ctl_i,
   // ingress packet
   input wire logic rx_pkt_i,
   input wire logic [2:0] rx_vlan_memb_i,
   input wire logic rx_vid_is_pvid_i,
   // egress packet
   input wire logic tx_pkt_i,
   // decisions
   output logic rx_drop_o,
   output logic rx_learn_o,
   output logic rx_mirror_o,
   output logic tx_block_o,
   output logic tx_mirror_o
);
   logic drop;
   always_comb begin
      drop = 1'b0;
      if (!ctl_i[SPSC_CT_RX_EN]) drop = 1'b1;
      if (ctl_i[SPSC_CT_VLAN_FILT] && ((rx_vlan_memb_i & SPSC_MEMB_HOST) == 3'h0)) begin
         drop = 1'b1;
      end
      if (ctl_i[SPSC_CT_NONPVID] && !rx_vid_is_pvid_i) drop = 1'b1;
   end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rx_drop_o <= 1'b0;
         rx_learn_o <= 1'b0;
         rx_mirror_o <= 1'b0;
      end else begin
         rx_drop_o <= rx_pkt_i && drop;
         rx_learn_o <= rx_pkt_i && !drop && !ctl_i[SPSC_CT_LEARN_DIS];
         rx_mirror_o <= rx_pkt_i && !drop && ctl_i[SPSC_CT_RX_SNIFF];
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         tx_block_o <= 1'b0;
         tx_mirror_o <= 1'b0;
      end else begin
         tx_block_o <= tx_pkt_i && !ctl_i[SPSC_CT_TX_EN];
         tx_mirror_o <= tx_pkt_i && ctl_i[SPSC_CT_TX_EN] && ctl_i[SPSC_CT_TX_SNIFF];
      end
   end
endmodule // spsc_gate
`default_nettype wire

// ==== rtl/spsc_top.sv ====
// Purpose: port two link status and host port control register pair
// Assumes: inputs synchronous to clk_i; one-cycle strobes, never both at once
// Notes: read data appear the cycle after the read strobe only
`timescale 1ns/10ps
`default_nettype none
module spsc_top
   import spsc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // physical layer status
   input wire logic pol_rev_i,
   input wire logic rx_pause_act_i,
   input wire logic tx_pause_act_i,
   input wire logic speed_100_i,
   input wire logic full_duplex_i,
   input wire logic mdi_i,
   input wire logic an_done_i,
   input wire logic link_good_i,
   input wire logic [4:0] lp_ability_i,
   // packet qualifiers
   input wire logic rx_pkt_i,
   input wire logic [2:0] rx_vlan_memb_i,
   input wire logic rx_vid_is_pvid_i,
   input wire logic tx_pkt_i,
   // control to the physical layer and switch
   output logic crossover_variant_select_o,
   output logic mirror_dest_o,
   output logic rx_drop_o,
   output logic rx_learn_o,
   output logic rx_mirror_o,
   output logic tx_block_o,
   output logic tx_mirror_o
);
   logic [15:0] stat_rw;
   logic [15:0] ctl_q;
   logic [15:0] stat_view;
   logic wr_stat;
   logic wr_ctl;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign wr_stat = wr_i && hit(addr_i, SPSC_OFF_LINK_STAT);
   assign wr_ctl = wr_i && hit(addr_i, SPSC_OFF_HOST_CTL2);

   // writable bits only; others ignore writes
   spsc_regbit #(
      .W(SPSC_DW),
      .MASK(SPSC_ST_WMASK),
      .RST(SPSC_ST_RESET)
   ) u_stat_rw (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .we_i(wr_stat),
      .wdata_i(wdata_i),
      .q_o(stat_rw)
   );

   spsc_regbit #(
      .W(SPSC_DW),
      .MASK(SPSC_CT_WMASK),
      .RST(SPSC_CT_RESET)
   ) u_ctl (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .we_i(wr_ctl),
      .wdata_i(wdata_i),
      .q_o(ctl_q)
   );

   // live status view
   always_comb begin
      stat_view = stat_rw;
      stat_view[SPSC_ST_POLREV] = pol_rev_i;
      stat_view[SPSC_ST_RXFC] = rx_pause_act_i;
      stat_view[SPSC_ST_TXFC] = tx_pause_act_i;
      stat_view[SPSC_ST_SPEED] = speed_100_i;
      stat_view[SPSC_ST_DUPLEX] = full_duplex_i;
      stat_view[SPSC_ST_MDI] = mdi_i;
      stat_view[SPSC_ST_ANDONE] = an_done_i;
      stat_view[SPSC_ST_LINK] = link_good_i;
      stat_view[SPSC_ST_LP_PAUSE] = lp_ability_i[4];
      stat_view[SPSC_ST_LP_100FD] = lp_ability_i[3];
      stat_view[SPSC_ST_LP_100HD] = lp_ability_i[2];
      stat_view[SPSC_ST_LP_10FD] = lp_ability_i[1];
      stat_view[SPSC_ST_LP_10HD] = lp_ability_i[0];
   end

   // read data, one cycle after strobe
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i && hit(addr_i, SPSC_OFF_LINK_STAT)) begin
         rdata_o <= stat_view;
      end else if (rd_i && hit(addr_i, SPSC_OFF_HOST_CTL2)) begin
         rdata_o <= ctl_q;
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // control levels out
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         crossover_variant_select_o <= SPSC_ST_RESET[SPSC_ST_XOVER];
         mirror_dest_o <= 1'b0;
      end else begin
         crossover_variant_select_o <= stat_rw[SPSC_ST_XOVER];
         mirror_dest_o <= ctl_q[SPSC_CT_MIRROR_DST];
      end
   end

   spsc_gate u_gate (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ctl_i(ctl_q),
      .rx_pkt_i(rx_pkt_i),
      .rx_vlan_memb_i(rx_vlan_memb_i),
      .rx_vid_is_pvid_i(rx_vid_is_pvid_i),
      .tx_pkt_i(tx_pkt_i),
      .rx_drop_o(rx_drop_o),
      .rx_learn_o(rx_learn_o),
      .rx_mirror_o(rx_mirror_o),
      .tx_block_o(tx_block_o),
      .tx_mirror_o(tx_mirror_o)
   );
endmodule // spsc_top
`default_nettype wire

// ==== test/spsc_props.sv ====
// Purpose: checks for the link status and host port control pair
// Assumes: one clock, synchronous active-low reset
// Notes: shadow copy of control tracks writes
`timescale 1ns/10ps
`default_nettype none
module spsc_props
   import spsc_pkg::*;
(
   // clock, reset, register port
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   // status and packets
   input wire logic pol_rev_i,
   input wire logic speed_100_i,
   input wire logic [4:0] lp_ability_i,
   input wire logic rx_pkt_i,
   input wire logic [2:0] rx_vlan_memb_i,
   input wire logic rx_vid_is_pvid_i,
   input wire logic tx_pkt_i,
   // crossover select and decisions
   input wire logic crossover_variant_select_o,
   input wire logic rx_drop_o,
   input wire logic rx_learn_o,
   input wire logic rx_mirror_o,
   input wire logic tx_block_o,
   input wire logic tx_mirror_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic [15:0] ctl_reg;
   logic drop_x;
   assign drop_x = !ctl_reg[9] | (ctl_reg[14] & !rx_vlan_memb_i[2]) |
      (ctl_reg[13] & !rx_vid_is_pvid_i);
   always_ff @(posedge clk_i) begin
      if (!rstn_i) ctl_reg <= SPSC_CT_RESET;
      else if (wr_i && addr_i == SPSC_OFF_HOST_CTL2) ctl_reg <= wdata_i & SPSC_CT_WMASK;
   end
   rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0) else $error("rdata not idle");
   ctl_read_a: assert property (rd_i && addr_i == SPSC_OFF_HOST_CTL2 |=>
      rdata_o == $past(ctl_reg)) else $error("control readback wrong");
   stat_live_a: assert property (rd_i && addr_i == SPSC_OFF_LINK_STAT |=>
      rdata_o[14:13] == {1'b0, $past(pol_rev_i)} && rdata_o[10] == $past(speed_100_i) &&
      rdata_o[8] == 1'b0 && rdata_o[4:0] == $past(lp_ability_i)) else $error("status wrong");
   xover_out_a: assert property (wr_i && addr_i == SPSC_OFF_LINK_STAT |=> ##1
      crossover_variant_select_o == $past(wdata_i[15], 2)) else $error("crossover select wrong");
   rx_drop_a: assert property (rx_pkt_i |=> rx_drop_o == $past(drop_x))
      else $error("drop wrong");
   rx_learn_a: assert property (rx_pkt_i |=> rx_learn_o == !$past(drop_x | ctl_reg[8]))
      else $error("learn wrong");
   rx_mirror_a: assert property (rx_pkt_i |=> rx_mirror_o == $past(!drop_x & ctl_reg[6]))
      else $error("rx mirror wrong");
   tx_block_a: assert property (tx_pkt_i |=> tx_block_o != $past(ctl_reg[10]))
      else $error("tx block wrong");
   tx_mirror_a: assert property (tx_pkt_i |=> tx_mirror_o == $past(ctl_reg[10] & ctl_reg[5]))
      else $error("tx mirror wrong");
   cover property (rx_pkt_i ##1 rx_drop_o);
   cover property (rx_pkt_i ##1 rx_mirror_o);
   cover property (tx_pkt_i ##1 tx_block_o);
endmodule // spsc_props
`default_nettype wire

// ==== test/spsc_tb_top.sv ====
// Purpose: self-checking bench for the register pair
// Assumes: register strobes driven by nonblocking assignment at rising edges
// Notes: table rows first, then packet and reset cases
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin err_total++; \
   $display("mismatch t=%0t %h %h", $time, a, b); end end
module spsc_tb_top
   import spsc_pkg::*;
;
   typedef struct {logic [7:0] a; logic [15:0] w; logic [12:0] s; logic [15:0] e;} spsc_row_t;
   spsc_row_t rows [6] = '{'{8'h02, 16'hffff, 13'h0000, 16'h67e0},
      '{8'h02, 16'h0000, 13'h0000, 16'h0000}, '{8'h04, 16'hffff, 13'h1fff, 16'hbeff},
      '{8'h04, 16'h8000, 13'h0aaa, 16'h94aa}, '{8'h04, 16'h0000, 13'h1555, 16'h2a55},
      '{8'h06, 16'hffff, 13'h1555, 16'h0000}};
   logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic rx_pkt_i = 1'b0, tx_pkt_i = 1'b0, rx_vid_is_pvid_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000, rd_d, rdata_o;
   logic [12:0] st = 13'h0000;
   logic [2:0] rx_vlan_memb_i = 3'h0;
   logic crossover_variant_select_o, mirror_dest_o, rx_drop_o, rx_learn_o;
   logic rx_mirror_o, tx_block_o, tx_mirror_o;
   int err_total = 0, cmp_count = 0;
   spsc_top dut (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .pol_rev_i(st[12]), .rx_pause_act_i(st[11]), .tx_pause_act_i(st[10]),
      .speed_100_i(st[9]), .full_duplex_i(st[8]), .mdi_i(st[7]), .an_done_i(st[6]),
      .link_good_i(st[5]), .lp_ability_i(st[4:0]), .rx_pkt_i, .rx_vlan_memb_i,
      .rx_vid_is_pvid_i, .tx_pkt_i, .crossover_variant_select_o, .mirror_dest_o,
      .rx_drop_o, .rx_learn_o, .rx_mirror_o, .tx_block_o, .tx_mirror_o);
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic print_verdict();
      if (err_total == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rd_d = rdata_o;
   endtask
   task automatic pk(input logic [15:0] c, input logic [2:0] m, input logic p,
      input logic [4:0] e);
      wr(SPSC_OFF_HOST_CTL2, c);
      rx_pkt_i <= 1'b1;
      tx_pkt_i <= 1'b1;
      rx_vlan_memb_i <= m;
      rx_vid_is_pvid_i <= p;
      @(posedge clk_i);
      rx_pkt_i <= 1'b0;
      tx_pkt_i <= 1'b0;
      #1 `CHK({rx_drop_o, rx_learn_o, rx_mirror_o, tx_block_o, tx_mirror_o}, e)
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         st <= rows[i].s;
         rd(rows[i].a);
         `CHK(rd_d, rows[i].e)
      end
      `CHK(crossover_variant_select_o, 1'b0)
      pk(16'h4600, 3'h3, 1'b1, 5'b10000);
      pk(16'h4600, 3'h4, 1'b1, 5'b01000);
      pk(16'h2600, 3'h0, 1'b0, 5'b10000);
      pk(16'h2600, 3'h0, 1'b1, 5'b01000);
      pk(16'h0000, 3'h7, 1'b1, 5'b10010);
      pk(16'h0760, 3'h7, 1'b1, 5'b00101);
      pk(16'h0680, 3'h7, 1'b1, 5'b01000);
      `CHK(mirror_dest_o, 1'b1)
      @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      #1 `CHK({crossover_variant_select_o, mirror_dest_o}, 2'b10)
      rd(SPSC_OFF_LINK_STAT);
      `CHK(rd_d, 16'haa55)
      rd(SPSC_OFF_HOST_CTL2);
      `CHK(rd_d, 16'h0600)
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end
endmodule // spsc_tb_top
bind spsc_top spsc_props u_props (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .pol_rev_i, .speed_100_i, .lp_ability_i, .rx_pkt_i, .rx_vlan_memb_i,
   .rx_vid_is_pvid_i, .tx_pkt_i, .crossover_variant_select_o, .rx_drop_o, .rx_learn_o,
   .rx_mirror_o, .tx_block_o, .tx_mirror_o);
`default_nettype wire
